/* File: dv/pwm_gen_tb_top.sv */
// bench: apb writes set duty and clock select, the pin model measures
// assumes pwm_gen, pwm_params.svh and pwm_pin_mon
`timescale 1ns/1ps
`include "pwm_params.svh"
module pwm_gen_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic pready, pslverr, pwm_out;
  logic [31:0] rdat;
  int hi, per, bad_count = 0, tests_run = 0, cyc = 0;
  always #4 pclk = ~pclk;
  pwm_gen dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
  pwm_pin_mon pin_u (.clk(pclk), .pin(pwm_out), .hi(hi), .per(per));
  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (e !== s) begin
      bad_count++;
      $display("FAIL %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, d);
    {psel, pwrite, paddr, pwdata} <= {2'b11, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    {psel, pwrite, paddr} <= {2'b10, a};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : rd
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(`PWM_ADDR_DATA_HIGH, 32'he1);
    chk("slverr", 32'h0, {31'h0, err});
    wr(`PWM_ADDR_DATA_LOW, 32'h02);
    rd(`PWM_ADDR_DATA_LOW, rdat);
    chk("read_zero", 32'h0, rdat);
    wr(32'h3ff4c, 32'h01);
    chk("unmapped", 32'h1, {31'h0, err});
    repeat (34500) @(posedge pclk);
    chk("high_div2", 32'd8450, hi);
    chk("period_div2", `PWM_PERIOD_FAST, per);
    wr(`PWM_ADDR_CONTROL, 32'h01);
    repeat (58000) @(posedge pclk);
    chk("high_div4", 32'd16900, hi);
    chk("period_div4", `PWM_PERIOD_SLOW, per);
    end_sim();
  end
endmodule : pwm_gen_tb_top

/* File: dv/pwm_pin_mon.sv */
// pin model: measures high width and period of the waveform
// assumes the pin is sampled on the system clock
`timescale 1ns/1ps
module pwm_pin_mon (
  // pin side
  input wire logic clk,
  input wire logic pin,
  output int hi,
  output int per
);
  logic q = 1'b0;
  int h = 0;
  int p = 0;
  always @(posedge clk) begin
    if (pin && !q) begin
      per <= p;
      p <= 1;
      h <= 1;
    end else begin
      p <= p + 1;
      h <= h + pin;
    end
    if (!pin && q) hi <= h;
    q <= pin;
  end
endmodule : pwm_pin_mon

/* File: verilog/pwm_gen.sv */
// 14-bit pwm generator with apb register access
// assumes apb master in the pclk domain; pwm_out drives an output pin
//
// Function
// - select 0 gives clock/2 input, full period 16384 system cycles.
// - select 0 gives a one system cycle duty step.
// - high data register keeps duty bits 13..8 in bits 5..0.
// - low data register keeps duty bits 7..0.
`timescale 1ns/1ps
`include "pwm_params.svh"

module pwm_gen #(
  parameter int DUTY_BITS = 14
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pin
  output logic pwm_out
);

  // elaboration check: the duty value is the two data registers side by side
  if (DUTY_BITS != `PWM_HIGH_BITS + `PWM_LOW_BITS) begin : g_bad_width
    $error("DUTY_BITS must equal the data register widths");
  end

  // one bit more than the duty value covers the slow period
  localparam int CNT_BITS = DUTY_BITS + 1;
  localparam logic [CNT_BITS-1:0] FAST_LAST = CNT_BITS'(`PWM_PERIOD_FAST - 1);
  localparam logic [CNT_BITS-1:0] SLOW_LAST = CNT_BITS'(`PWM_PERIOD_SLOW - 1);

  // register state
  pwm_pkg::pwm_duty_t duty;
  pwm_pkg::pwm_div_t clock_divider_select;

  // period counter and compare
  logic [CNT_BITS-1:0] cycle_count;
  logic [CNT_BITS-1:0] next_cycle_count;
  logic [CNT_BITS-1:0] last_count;
  logic period_end;
  logic [DUTY_BITS-1:0] position;
  logic [DUTY_BITS-1:0] duty_value;
  logic duty_hit;
  logic next_pwm_out;

  // bus decode
  logic access;
  logic wr_en;
  logic upper_zero;
  logic sel_control;
  logic sel_high;
  logic sel_low;
  logic addr_hit;
  logic wr_control;
  logic wr_high;
  logic wr_low;

  // a transfer is taken at the access edge; zero wait states
  assign access = psel && penable;
  assign wr_en = access && pwrite;

  // byte address is four times the register index; upper bits must be clear
  assign upper_zero = (paddr[31:18] == 14'h0000);
  assign sel_control = upper_zero && (paddr[17:0] == `PWM_ADDR_CONTROL);
  assign sel_high = upper_zero && (paddr[17:0] == `PWM_ADDR_DATA_HIGH);
  assign sel_low = upper_zero && (paddr[17:0] == `PWM_ADDR_DATA_LOW);
  assign addr_hit = sel_control || sel_high || sel_low;

  assign wr_control = wr_en && sel_control;
  assign wr_high = wr_en && sel_high;
  assign wr_low = wr_en && sel_low;

  // unmapped addresses are refused and change nothing
  assign pready = 1'b1;
  assign pslverr = access && !addr_hit;

  // registers are write only; reads return zero
  assign prdata = 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider_select <= pwm_pkg::pwm_div_t'(`PWM_SEL_RESET);
    end else if (wr_control) begin
      clock_divider_select <= pwm_pkg::pwm_div_t'(pwdata[0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty.high <= `PWM_HIGH_RESET;
    end else if (wr_high) begin
      duty.high <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty.low <= `PWM_LOW_RESET;
    end else if (wr_low) begin
      duty.low <= pwdata[7:0];
    end
  end

  always_comb begin
    case (clock_divider_select)
      pwm_pkg::PWM_DIV2: begin
        last_count = FAST_LAST;
      end
      pwm_pkg::PWM_DIV4: begin
        last_count = SLOW_LAST;
      end
      default: begin
        last_count = FAST_LAST;
      end
    endcase
  end

  // at or past the end, so a switch to /2 late in a slow period still wraps
  assign period_end = (cycle_count >= last_count);

  always_comb begin
    if (period_end) begin
      next_cycle_count = '0;
    end else begin
      next_cycle_count = cycle_count + CNT_BITS'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_count <= '0;
    end else begin
      cycle_count <= next_cycle_count;
    end
  end

  // one cycle per step at /2, two at /4
  always_comb begin
    case (clock_divider_select)
      pwm_pkg::PWM_DIV2: begin
        position = cycle_count[DUTY_BITS-1:0];
      end
      pwm_pkg::PWM_DIV4: begin
        position = cycle_count[DUTY_BITS:1];
      end
      default: begin
        position = cycle_count[DUTY_BITS-1:0];
      end
    endcase
  end

  assign duty_value = duty;
  assign duty_hit = (position < duty_value);
  assign next_pwm_out = duty_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= next_pwm_out;
    end
  end

  // checks on counter, step and output

  sequence s_restart;
    cycle_count == '0;
  endsequence

  sequence s_slow_odd_step;
    (clock_divider_select == pwm_pkg::PWM_DIV4) && cycle_count[0] &&
      $stable(duty) && $stable(clock_divider_select);
  endsequence

  sequence s_fast_duty_reached;
    (clock_divider_select == pwm_pkg::PWM_DIV2) && $stable(clock_divider_select) &&
      $stable(duty) && (duty_value != '0) && (position == duty_value);
  endsequence

  a_period_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    period_end
    |=> s_restart)
    else $error("period counter did not restart");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    !period_end
    |=> (cycle_count == $past(cycle_count) + CNT_BITS'(1)))
    else $error("period counter did not advance");

  a_fast_length: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_divider_select == pwm_pkg::PWM_DIV2) && ($past(clock_divider_select) == pwm_pkg::PWM_DIV2)
    |-> (cycle_count <= FAST_LAST))
    else $error("fast period too long");

  a_fast_wrap_point: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_divider_select == pwm_pkg::PWM_DIV2) && (cycle_count == FAST_LAST)
    |-> period_end)
    else $error("fast period did not end");

  a_fast_no_early_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_divider_select == pwm_pkg::PWM_DIV2) && (cycle_count < FAST_LAST)
    |-> !period_end)
    else $error("fast period ended early");

  a_slow_wrap_point: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_divider_select == pwm_pkg::PWM_DIV4) && (cycle_count == SLOW_LAST)
    |-> period_end)
    else $error("slow period did not end");

  a_slow_no_early_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_divider_select == pwm_pkg::PWM_DIV4) && (cycle_count < SLOW_LAST)
    |-> !period_end)
    else $error("slow period ended early");

  a_fast_step: assert property (@(posedge pclk) disable iff (!presetn)
    s_fast_duty_reached
    |=> $fell(pwm_out))
    else $error("fast output did not fall at the duty count");

  a_fast_position: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_divider_select == pwm_pkg::PWM_DIV2)
    |-> (position == cycle_count[DUTY_BITS-1:0]))
    else $error("fast position wrong");

  a_slow_step: assert property (@(posedge pclk) disable iff (!presetn)
    s_slow_odd_step
    |=> $stable(pwm_out))
    else $error("slow output changed inside a step");

  a_slow_position: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_divider_select == pwm_pkg::PWM_DIV4)
    |-> (position == cycle_count[DUTY_BITS:1]))
    else $error("slow position wrong");

  a_high_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high
    |=> (duty.high == $past(pwdata[5:0])))
    else $error("upper duty bits not written");

  a_high_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_high
    |=> $stable(duty.high))
    else $error("upper duty bits changed without a write");

  a_low_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low
    |=> (duty.low == $past(pwdata[7:0])))
    else $error("lower duty bits not written");

  a_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_low
    |=> $stable(duty.low))
    else $error("lower duty bits changed without a write");

  a_select_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_control
    |=> (clock_divider_select == pwm_pkg::pwm_div_t'($past(pwdata[0]))))
    else $error("clock select not written");

  a_zero_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (duty_value == '0)
    |=> !pwm_out)
    else $error("output high with zero duty");

  a_start_high: assert property (@(posedge pclk) disable iff (!presetn)
    (cycle_count == '0) && (duty_value != '0)
    |=> pwm_out)
    else $error("output not high at period start");

  a_high_below_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (position < duty_value)
    |=> pwm_out)
    else $error("output low below the duty count");

  a_low_at_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (position >= duty_value)
    |=> !pwm_out)
    else $error("output high at or past the duty count");

endmodule : pwm_gen

/* File: verilog/pwm_params.svh */
// pwm generator register map and timing constants
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH
`define PWM_OFS_CONTROL 16'hffd0
`define PWM_OFS_DATA_HIGH 16'hffd1
`define PWM_OFS_DATA_LOW 16'hffd2
`define PWM_ADDR_CONTROL 18'h3ff40
`define PWM_ADDR_DATA_HIGH 18'h3ff44
`define PWM_ADDR_DATA_LOW 18'h3ff48
`define PWM_HIGH_BITS 6
`define PWM_LOW_BITS 8
`define PWM_HIGH_RESET 6'h00
`define PWM_LOW_RESET 8'h00
`define PWM_SEL_RESET 1'h0
`define PWM_DIV_FAST 2
`define PWM_DIV_SLOW 4
`define PWM_PERIOD_FAST 16384
`define PWM_PERIOD_SLOW 32768
`endif

/* File: verilog/pwm_pkg.sv */
// pwm generator types
// field widths are written as numbers here and must match pwm_params.svh
package pwm_pkg;
  typedef struct packed {
    logic [5:0] high;
    logic [7:0] low;
  } pwm_duty_t;
  typedef enum logic {
    PWM_DIV2,
    PWM_DIV4
  } pwm_div_t;
endpackage : pwm_pkg
